// ===== design/sgs_pkg.sv
// constants shared by the setting group selector files
package sgs_pkg;
    // register byte offsets
    localparam logic [5:0] OFS_STATUS = 6'h00;
    localparam logic [5:0] OFS_CONFIG = 6'h04;
    localparam logic [5:0] OFS_QUAL = 6'h08;
    localparam logic [5:0] OFS_DEB = 6'h0c;
    localparam logic [5:0] OFS_CMD = 6'h10;
    localparam logic [5:0] OFS_BITS = 6'h14;
    localparam logic [5:0] OFS_EDIT = 6'h18;
    // status fields
    localparam int ST_G1 = 0;
    localparam int ST_G2 = 1;
    localparam int ST_DIS = 2;
    localparam int ST_LATCH = 3;
    localparam int ST_IN = 4;
    localparam int ST_PEND = 5;
    // config, edit, command and bits fields
    localparam int CFG_SRC = 0;
    localparam int EDIT_GRP = 0;
    localparam int TOGGLE_IDX = 4;
    localparam logic [1:0] CMD_G1 = 2'h1;
    localparam logic [1:0] CMD_G2 = 2'h2;
    // reset values
    localparam logic CFG_SRC_RST = 1'h1;
    localparam logic [15:0] QUAL_RST = 16'h0004;
    localparam logic [7:0] DEB_RST = 8'h02;
    // bus responses
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
    // timing: clock period, processing interval, disable window
    localparam int CLK_NS = 5;
    localparam int TICK_NS = 4166667;
    localparam int TICK_CYCLES = TICK_NS / CLK_NS;
    localparam int DISABLE_MS = 2000;
    localparam int DISABLE_TICKS = (DISABLE_MS * 1000) / (TICK_NS / 1000);
    typedef enum logic [1:0] {
        SGS_RUN = 2'b00,
        SGS_QUAL = 2'b01,
        SGS_DIS = 2'b10
    } sgs_state_t;
endpackage

// ===== design/sgs_edge_if.sv
// carrier between the core and the input conditioner
`timescale 1ns/1ps
interface sgs_edge_if;
    logic tick;
    logic raw;
    logic [7:0] deb_ticks;
    logic status;
    logic rise;
    modport core (output tick, output raw, output deb_ticks,
                  input status, input rise);
    modport cond (input tick, input raw, input deb_ticks,
                  output status, output rise);
endinterface

// ===== design/sgs_edge.sv
// debounce timer and rising edge operator for the pulse input
`timescale 1ns/1ps
module sgs_edge (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // conditioned input
    sgs_edge_if.cond e
);
    logic [7:0] cnt_reg;
    logic status_reg;
    logic prev_reg;
    logic rise_reg;

    wire differ = e.raw != status_reg;
    wire settled = cnt_reg >= e.deb_ticks;

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            cnt_reg <= 8'h00;
            status_reg <= 1'b0;
        end else if (e.tick) begin
            if (!differ) begin
                cnt_reg <= 8'h00;
            end else if (settled) begin
                cnt_reg <= 8'h00;
                status_reg <= e.raw;
            end else begin
                cnt_reg <= cnt_reg + 8'h01;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            prev_reg <= 1'b0;
            rise_reg <= 1'b0;
        end else if (e.tick) begin
            prev_reg <= status_reg;
            rise_reg <= status_reg & ~prev_reg;
        end
    end

    assign e.status = status_reg;
    assign e.rise = rise_reg;

    AST_RISE_ONE_INTERVAL: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (e.tick && rise_reg) |=> !rise_reg)
        else $error("edge pulse lasted past one interval");

    AST_RISE_ON_TICK: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        $rose(rise_reg) |-> $past(e.tick) && $past(status_reg) &&
        !$past(prev_reg))
        else $error("edge pulse without a debounced rise");
endmodule // sgs_edge

// ===== design/sgs_top.sv
// setting group selector with its register slave
//
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module sgs_top #(
    parameter int TICK_CYC = sgs_pkg::TICK_CYCLES,
    parameter int DIS_TICKS = sgs_pkg::DISABLE_TICKS
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // register bus
    input wire logic [5:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [5:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // field inputs
    input wire logic pulse_contact_input,
    input wire logic ext_sel1,
    input wire logic ext_sel2,
    input wire logic panel_group_btn,
    // nonvolatile store
    input wire logic nvm_group_in,
    output logic nvm_wr,
    output logic nvm_wr_group,
    // group outputs
    output logic group1_active_flag,
    output logic group2_active_flag,
    output logic protection_disabled
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    sgs_pkg::sgs_state_t state_reg;
    sgs_pkg::sgs_state_t state_next;
    logic [19:0] tick_cnt_reg;
    logic tick_reg;
    logic aw_rdy_reg, w_rdy_reg, aw_hold_reg, w_hold_reg;
    logic [5:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic bvalid_reg, ar_rdy_reg, rvalid_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;
    logic cfg_src_reg;
    logic [15:0] qual_reg;
    logic [7:0] deb_reg;
    logic [15:0] local_bits_reg;
    logic [15:0] latch_bits_reg;
    logic group_reg, restore_reg;
    logic cmd_pend_reg, cmd_tgt_reg, btn_pend_reg, btn_prev_reg;
    logic [15:0] qual_cnt_reg;
    logic [15:0] dis_cnt_reg;
    logic g1_flag_reg, g2_flag_reg, dis_flag_reg;
    logic nvm_wr_reg, nvm_grp_reg;
    logic [31:0] status_word;

    // processing interval divider
    wire tick_wrap = tick_cnt_reg == 20'(TICK_CYC - 1);
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            tick_cnt_reg <= 20'h00000;
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= tick_wrap;
            tick_cnt_reg <= tick_wrap ? 20'h00000 : tick_cnt_reg + 20'h00001;
        end
    end

    // write channel: address and data taken in either order
    wire aw_take = s_axi_awvalid & aw_rdy_reg;
    wire w_take = s_axi_wvalid & w_rdy_reg;
    wire do_write = aw_hold_reg & w_hold_reg & ~bvalid_reg;
    wire aw_hold_next = (aw_hold_reg & ~do_write) | aw_take;
    wire w_hold_next = (w_hold_reg & ~do_write) | w_take;
    wire wr_cfg = do_write & (aw_addr_reg == sgs_pkg::OFS_CONFIG);
    wire wr_qual = do_write & (aw_addr_reg == sgs_pkg::OFS_QUAL);
    wire wr_deb = do_write & (aw_addr_reg == sgs_pkg::OFS_DEB);
    wire wr_cmd = do_write & (aw_addr_reg == sgs_pkg::OFS_CMD);
    wire wr_bits = do_write & (aw_addr_reg == sgs_pkg::OFS_BITS);
    wire wr_edit = do_write & (aw_addr_reg == sgs_pkg::OFS_EDIT);
    wire wr_hit = wr_cfg | wr_qual | wr_deb | wr_cmd | wr_bits | wr_edit;
    wire [31:0] wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                         {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
    wire [31:0] wval = w_data_reg & wmask;
    wire [31:0] bits_new = ({latch_bits_reg, local_bits_reg} & ~wmask) | wval;
    wire [31:0] qual_new = ({16'h0000, qual_reg} & ~wmask) | wval;
    wire [31:0] cfg_new = ({31'h0, cfg_src_reg} & ~wmask) | wval;
    wire [31:0] deb_new = ({24'h000000, deb_reg} & ~wmask) | wval;

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            aw_rdy_reg <= 1'b0;
            w_rdy_reg <= 1'b0;
            aw_addr_reg <= 6'h00;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= sgs_pkg::RESP_OK;
        end else begin
            aw_hold_reg <= aw_hold_next;
            w_hold_reg <= w_hold_next;
            aw_rdy_reg <= ~aw_hold_next;
            w_rdy_reg <= ~w_hold_next;
            if (aw_take) aw_addr_reg <= s_axi_awaddr;
            if (w_take) begin
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (do_write) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_hit ? sgs_pkg::RESP_OK : sgs_pkg::RESP_ERR;
            end else if (s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // read channel
    wire ar_take = s_axi_arvalid & ar_rdy_reg;
    wire rvalid_next = ar_take | (rvalid_reg & ~s_axi_rready);
    wire rd_cmd = s_axi_araddr == sgs_pkg::OFS_CMD;
    wire rd_edit = s_axi_araddr == sgs_pkg::OFS_EDIT;
    wire rd_hit = (s_axi_araddr == sgs_pkg::OFS_STATUS) |
                  (s_axi_araddr == sgs_pkg::OFS_CONFIG) |
                  (s_axi_araddr == sgs_pkg::OFS_QUAL) |
                  (s_axi_araddr == sgs_pkg::OFS_DEB) |
                  (s_axi_araddr == sgs_pkg::OFS_BITS) | rd_cmd | rd_edit;
    wire [31:0] rd_word =
        (s_axi_araddr == sgs_pkg::OFS_STATUS) ? status_word :
        (s_axi_araddr == sgs_pkg::OFS_CONFIG) ? {31'h0, cfg_src_reg} :
        (s_axi_araddr == sgs_pkg::OFS_QUAL) ? {16'h0000, qual_reg} :
        (s_axi_araddr == sgs_pkg::OFS_DEB) ? {24'h000000, deb_reg} :
        (s_axi_araddr == sgs_pkg::OFS_BITS) ?
            {latch_bits_reg, local_bits_reg} : 32'h00000000;

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            rvalid_reg <= 1'b0;
            ar_rdy_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= sgs_pkg::RESP_OK;
        end else begin
            rvalid_reg <= rvalid_next;
            ar_rdy_reg <= ~rvalid_next;
            if (ar_take) begin
                rdata_reg <= rd_word;
                rresp_reg <= rd_hit ? sgs_pkg::RESP_OK : sgs_pkg::RESP_ERR;
            end
        end
    end

    // input conditioner
    sgs_edge_if ein();
    assign ein.tick = tick_reg;
    assign ein.raw = pulse_contact_input;
    assign ein.deb_ticks = deb_reg;
    sgs_edge u_edge (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .e(ein.cond)
    );

    // select equations and group decision
    wire toggle_latch_bit = latch_bits_reg[sgs_pkg::TOGGLE_IDX];
    wire group1_select_eq = cfg_src_reg ? toggle_latch_bit : ext_sel1;
    wire group2_select_eq = cfg_src_reg ? ~toggle_latch_bit : ext_sel2;
    wire cur_sel = group_reg ? group2_select_eq : group1_select_eq;
    wire oth_sel = group_reg ? group1_select_eq : group2_select_eq;
    wire want_switch = ~cur_sel & oth_sel;
    wire manual_ok = ~group1_select_eq & ~group2_select_eq;
    wire in_run = state_reg == sgs_pkg::SGS_RUN;
    wire in_qual = state_reg == sgs_pkg::SGS_QUAL;
    wire in_dis = state_reg == sgs_pkg::SGS_DIS;
    wire run_tick = tick_reg & in_run & restore_reg;
    wire manual_req = (cmd_pend_reg & (cmd_tgt_reg != group_reg)) |
                      btn_pend_reg;
    wire do_manual = run_tick & manual_ok & manual_req;
    wire qual_done = tick_reg & want_switch &
        ((run_tick & (qual_reg == 16'h0000)) |
         (in_qual & (qual_cnt_reg >= qual_reg)));
    wire do_change = do_manual | qual_done;
    wire edit_active = wr_edit & ~in_dis &
                       (w_data_reg[sgs_pkg::EDIT_GRP] == group_reg);
    wire cmd_ok = wr_cmd & ((w_data_reg[1:0] == sgs_pkg::CMD_G1) |
                            (w_data_reg[1:0] == sgs_pkg::CMD_G2));
    wire btn_rise = panel_group_btn & ~btn_prev_reg;
    wire pend_drop = run_tick | in_dis;
    // steer the edge by the latch
    wire toggle_latch_set_eq = ein.rise & ~toggle_latch_bit;
    wire toggle_latch_reset_eq = ein.rise & toggle_latch_bit;
    wire latch_step = tick_reg & ~in_dis;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            sgs_pkg::SGS_RUN: begin
                if (do_change | edit_active) state_next = sgs_pkg::SGS_DIS;
                else if (run_tick & want_switch)
                    state_next = sgs_pkg::SGS_QUAL;
            end
            sgs_pkg::SGS_QUAL: begin
                if (do_change | edit_active) state_next = sgs_pkg::SGS_DIS;
                else if (tick_reg & ~want_switch)
                    state_next = sgs_pkg::SGS_RUN;
            end
            sgs_pkg::SGS_DIS: begin
                if (tick_reg & (dis_cnt_reg == 16'(DIS_TICKS - 1)))
                    state_next = sgs_pkg::SGS_RUN;
            end
            default: state_next = sgs_pkg::SGS_RUN;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state_reg <= sgs_pkg::SGS_RUN;
            qual_cnt_reg <= 16'h0001;
            dis_cnt_reg <= 16'h0000;
        end else begin
            state_reg <= state_next;
            if (!in_qual) qual_cnt_reg <= 16'h0001;
            else if (tick_reg) qual_cnt_reg <= qual_cnt_reg + 16'h0001;
            if (!in_dis) dis_cnt_reg <= 16'h0000;
            else if (tick_reg) dis_cnt_reg <= dis_cnt_reg + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            restore_reg <= 1'b0;
            group_reg <= 1'b0;
        end else begin
            restore_reg <= 1'b1;
            if (!restore_reg) group_reg <= nvm_group_in;
            // only a change flips the group
            else if (do_change) group_reg <= ~group_reg;
        end
    end

    // pending manual requests; a new one wins over the drop
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            cmd_pend_reg <= 1'b0;
            cmd_tgt_reg <= 1'b0;
            btn_pend_reg <= 1'b0;
            btn_prev_reg <= 1'b0;
        end else begin
            btn_prev_reg <= panel_group_btn;
            cmd_pend_reg <= cmd_ok | (cmd_pend_reg & ~pend_drop);
            btn_pend_reg <= btn_rise | (btn_pend_reg & ~pend_drop);
            if (cmd_ok) cmd_tgt_reg <= w_data_reg[1:0] == sgs_pkg::CMD_G2;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            cfg_src_reg <= sgs_pkg::CFG_SRC_RST;
            qual_reg <= sgs_pkg::QUAL_RST;
            deb_reg <= sgs_pkg::DEB_RST;
            local_bits_reg <= 16'h0000;
            latch_bits_reg <= 16'h0000;
        end else begin
            if (wr_cfg) cfg_src_reg <= cfg_new[sgs_pkg::CFG_SRC];
            if (wr_qual) qual_reg <= qual_new[15:0];
            if (wr_deb) deb_reg <= deb_new[7:0];
            if (wr_bits) local_bits_reg <= bits_new[15:0];
            if (wr_bits) latch_bits_reg <= bits_new[31:16];
            // latch moves at the next tick unless that tick is in the disable window
            if (latch_step & toggle_latch_set_eq)
                latch_bits_reg[sgs_pkg::TOGGLE_IDX] <= 1'b1;
            if (latch_step & toggle_latch_reset_eq)
                latch_bits_reg[sgs_pkg::TOGGLE_IDX] <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            g1_flag_reg <= 1'b1;
            g2_flag_reg <= 1'b0;
            dis_flag_reg <= 1'b0;
            nvm_wr_reg <= 1'b0;
            nvm_grp_reg <= 1'b0;
        end else begin
            g1_flag_reg <= ~group_reg;
            g2_flag_reg <= group_reg;
            dis_flag_reg <= state_next == sgs_pkg::SGS_DIS;
            nvm_wr_reg <= do_change;
            if (do_change) nvm_grp_reg <= ~group_reg;
        end
    end

    always_comb begin
        status_word = 32'h00000000;
        status_word[sgs_pkg::ST_G1] = g1_flag_reg;
        status_word[sgs_pkg::ST_G2] = g2_flag_reg;
        status_word[sgs_pkg::ST_DIS] = dis_flag_reg;
        status_word[sgs_pkg::ST_LATCH] = toggle_latch_bit;
        status_word[sgs_pkg::ST_IN] = ein.status;
        status_word[sgs_pkg::ST_PEND] = cmd_pend_reg | btn_pend_reg;
    end

    assign s_axi_awready = aw_rdy_reg;
    assign s_axi_wready = w_rdy_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = ar_rdy_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign group1_active_flag = g1_flag_reg;
    assign group2_active_flag = g2_flag_reg;
    assign protection_disabled = dis_flag_reg;
    assign nvm_wr = nvm_wr_reg;
    assign nvm_wr_group = nvm_grp_reg;

    sequence s_changed;
        $past(restore_reg) && $changed(group_reg);
    endsequence
    sequence s_disabled;
        in_dis && protection_disabled ##1 protection_disabled;
    endsequence

    AST_SELECT_BLOCKS_MANUAL: assert property (
        s_changed |-> $past(want_switch) || $past(manual_ok))
        else $error("group changed by a manual request under a select");
    AST_MANUAL_ACCEPTED: assert property (
        (run_tick && manual_ok && btn_pend_reg) |=> $changed(group_reg))
        else $error("manual request ignored with both selects low");
    AST_CHANGE_DISABLES: assert property (
        s_changed |-> s_disabled)
        else $error("group change without disable window");
    AST_LOCAL_BITS_KEPT: assert property (
        !wr_bits |=> $stable(local_bits_reg))
        else $error("local bits moved without a write");
    AST_LATCH_SET: assert property (
        (latch_step && ein.rise && !toggle_latch_bit) |=> toggle_latch_bit)
        else $error("latch not set after edge");
    AST_LATCH_HOLD: assert property (
        (tick_reg && !ein.rise && !wr_bits) |=> $stable(toggle_latch_bit))
        else $error("latch moved without an edge");
    AST_RESTORE: assert property (
        $rose(restore_reg) |-> group_reg == $past(nvm_group_in))
        else $error("stored group not restored");
    AST_OTHER_EDIT: assert property (
        (wr_edit && in_run && w_data_reg[0] != group_reg && !do_change)
        |=> !in_dis)
        else $error("edit of other group disabled the device");
    AST_NVM_WRITE: assert property (
        s_changed |-> nvm_wr && nvm_wr_group == group_reg)
        else $error("new group not written to store");
    AST_QUAL_ABORT: assert property (
        (tick_reg && in_qual && !want_switch && !edit_active)
        |=> in_run && $stable(group_reg))
        else $error("unqualified select changed the group");
    AST_ONE_FLAG: assert property (
        $onehot({group1_active_flag, group2_active_flag}) &&
        group2_active_flag == $past(group_reg))
        else $error("group flags not one-hot or stale");
    AST_STAY: assert property (
        (tick_reg && restore_reg && cur_sel) |=> $stable(group_reg))
        else $error("group left while its select is high");
    AST_QUAL_SWITCH: assert property (
        (tick_reg && in_qual && want_switch && qual_cnt_reg >= qual_reg)
        |=> $changed(group_reg) ##1 in_dis)
        else $error("qualified select did not switch");
endmodule // sgs_top

// ===== tb/sgs_field.sv
// model of the field side: contact, pushbutton and group store
`timescale 1ns/1ps
module sgs_field (
    // clock
    input wire logic sys_clk,
    // store write port
    input wire logic nvm_wr,
    input wire logic nvm_wr_group,
    // field lines
    output logic nvm_group_in,
    output logic pulse_contact_input,
    output logic panel_group_btn
);
    logic store_reg;
    initial begin
        {store_reg, pulse_contact_input, panel_group_btn} = 3'b000;
    end
    always @(posedge sys_clk) begin
        if (nvm_wr === 1'b1) begin
            store_reg <= nvm_wr_group;
        end
    end
    assign nvm_group_in = store_reg;
    task automatic contact(input logic v);
        @(posedge sys_clk);
        pulse_contact_input <= v;
    endtask
    task automatic press();
        @(posedge sys_clk);
        panel_group_btn <= 1'b1;
        repeat (16) @(posedge sys_clk);
        panel_group_btn <= 1'b0;
    endtask
endmodule // sgs_field

// ===== tb/sgs_top_bench.sv
// self-checking bench for the setting group selector
`timescale 1ns/1ps
module sgs_top_bench;
    localparam logic [1:0] OK = sgs_pkg::RESP_OK;
    localparam logic [5:0] ST = sgs_pkg::OFS_STATUS;
    logic sys_clk, rstn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, pulse_contact_input;
    logic ext_sel1, ext_sel2, panel_group_btn, nvm_group_in, nvm_wr;
    logic nvm_wr_group, group1_active_flag, group2_active_flag;
    logic protection_disabled;
    logic [5:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int fail_count = 0;
    int n_compared = 0;
    sgs_top #(.TICK_CYC(8), .DIS_TICKS(3)) dut (
        .sys_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .pulse_contact_input, .ext_sel1,
        .ext_sel2, .panel_group_btn, .nvm_group_in, .nvm_wr, .nvm_wr_group,
        .group1_active_flag, .group2_active_flag, .protection_disabled
    );
    sgs_field field (
        .sys_clk, .nvm_wr, .nvm_wr_group, .nvm_group_in,
        .pulse_contact_input, .panel_group_btn
    );
    always #2.5 sys_clk = ~sys_clk;
    task automatic give_verdict();
        if (fail_count == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, exp, input string m);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] v);
        int k;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (k = 0; k < 40 && s_axi_bvalid !== 1'b1; k++) begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        chk({29'h0, s_axi_bvalid, s_axi_bresp}, {29'h0, 1'b1, OK}, "write");
        s_axi_bready <= 1'b0;
    endtask
    task automatic rdc(input logic [5:0] a, input logic [1:0] er,
                       input logic [31:0] mask, exp, input string m);
        int k;
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (k = 0; k < 40 && s_axi_rvalid !== 1'b1; k++) begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        chk({29'h0, s_axi_rvalid, s_axi_rresp}, {29'h0, 1'b1, er}, "read");
        chk(s_axi_rdata & mask, exp, m);
        s_axi_rready <= 1'b0;
    endtask
    // waits for the store write of a group change, then checks the flags
    task automatic flip(input logic g);
        int k;
        for (k = 0; k < 300 && nvm_wr !== 1'b1; k++) @(posedge sys_clk);
        chk({30'h0, nvm_wr, nvm_wr_group}, {30'h0, 1'b1, g}, "store");
        #1;
        chk({29'h0, protection_disabled, group2_active_flag,
             group1_active_flag}, {29'h0, 1'b1, g, ~g}, "flags");
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic sel(input logic a, b);
        @(posedge sys_clk);
        ext_sel1 <= a;
        ext_sel2 <= b;
    endtask
    task automatic do_reset();
        @(posedge sys_clk);
        rstn <= 1'b0;
        idle(2);
        rstn <= 1'b1;
        idle(3);
    endtask
    initial begin
        #100000;
        fail_count++;
        give_verdict();
    end
    initial begin
        {sys_clk, rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, ext_sel1, ext_sel2} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        do_reset();
        rdc(ST, OK, 32'h7, 32'h1, "reset group");
        rdc(sgs_pkg::OFS_CONFIG, OK, '1, 32'h1, "config");
        rdc(sgs_pkg::OFS_QUAL, OK, '1, 32'h4, "qual");
        rdc(sgs_pkg::OFS_DEB, OK, '1, 32'h2, "deb");
        rdc(6'h1c, sgs_pkg::RESP_ERR, '0, '0, "unmapped");
        wr(sgs_pkg::OFS_CONFIG, 32'h0);
        wr(sgs_pkg::OFS_BITS, 32'h00a5_5a5a);
        fork
            field.press();
            flip(1'b1);
        join
        rdc(sgs_pkg::OFS_BITS, OK, '1, 32'h00a5_5a5a, "bits");
        idle(40);
        rdc(ST, OK, 32'h7, 32'h2, "window end");
        sel(1'b1, 1'b1);
        wr(sgs_pkg::OFS_CMD, {30'h0, sgs_pkg::CMD_G1});
        idle(80);
        rdc(ST, OK, 32'h7, 32'h2, "blocked");
        sel(1'b1, 1'b0);
        idle(20);
        rdc(ST, OK, 32'h3, 32'h2, "qualifying");
        flip(1'b0);
        idle(40);
        sel(1'b0, 1'b0);
        wr(sgs_pkg::OFS_EDIT, 32'h1);
        idle(16);
        rdc(ST, OK, 32'h7, 32'h1, "other edit");
        wr(sgs_pkg::OFS_EDIT, 32'h0);
        idle(10);
        rdc(ST, OK, 32'h7, 32'h5, "active edit");
        idle(40);
        wr(sgs_pkg::OFS_CMD, {30'h0, sgs_pkg::CMD_G2});
        flip(1'b1);
        idle(40);
        wr(sgs_pkg::OFS_CMD, {30'h0, sgs_pkg::CMD_G1});
        flip(1'b0);
        idle(40);
        wr(sgs_pkg::OFS_CONFIG, 32'h1);
        flip(1'b1);
        idle(40);
        field.contact(1'b1);
        idle(10);
        rdc(ST, OK, 32'h10, 32'h0, "debounce");
        flip(1'b0);
        idle(120);
        rdc(ST, OK, 32'h1f, 32'h19, "one toggle");
        field.contact(1'b0);
        idle(40);
        field.contact(1'b1);
        flip(1'b1);
        idle(40);
        do_reset();
        rdc(ST, OK, 32'h7, 32'h2, "restored");
        give_verdict();
    end
endmodule // sgs_top_bench
